// ---- core/dbb_pkg.sv ----
// dbb_pkg: register map, reset values, timing constants and state codes
// for the dead-band and blanking generator.
// assumes a 40 MHz pclk and an APB master with 32-bit data.
package dbb_pkg;
    // apb geometry
    localparam int ADDR_W = 8;  // byte address width
    localparam int DATA_W = 32; // apb data width
    localparam int CNT_W  = 6;  // width of every count setting
    localparam int ACC_W  = 12; // elapsed-time accumulator width, ns

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00; // output_gen_control0
    localparam logic [ADDR_W-1:0] OFS_RDB  = 8'h04; // rising_deadband_count
    localparam logic [ADDR_W-1:0] OFS_FDB  = 8'h08; // falling_deadband_count
    localparam logic [ADDR_W-1:0] OFS_RBLK = 8'h0C; // rising blank count
    localparam logic [ADDR_W-1:0] OFS_FBLK = 8'h10; // falling blank count
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h14; // status, read only

    // control field positions
    localparam int CTRL_EN_BIT  = 0; // generator enable
    localparam int CTRL_RDS_BIT = 1; // rising_delay_source_sel
    localparam int CTRL_FDS_BIT = 2; // falling_delay_source_sel
    localparam int CTRL_W       = 3; // implemented control bits

    // values after reset
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [CNT_W-1:0]  CNT_RST  = 6'h00;

    // timing: one delay element and the clock period, both in ns
    localparam int CLK_MHZ = 40;             // pclk rate
    localparam int ELEM_NS = 5;              // nominal delay element
    localparam int CLK_NS  = 1000 / CLK_MHZ; // pclk period, 25 ns

    // output sequencing states
    typedef enum logic [2:0] {
        DBB_IDLE     = 3'b000, // both drives off
        DBB_PRI_WAIT = 3'b001, // rising dead-band running
        DBB_PRI_ON   = 3'b010, // primary drive on
        DBB_CMP_WAIT = 3'b011, // falling dead-band running
        DBB_CMP_ON   = 3'b100  // complementary drive on
    } dbb_state_t;
endpackage : dbb_pkg

// ---- core/dbb_tmr_if.sv ----
// dbb_tmr_if: start/count/busy bundle between the sequencer and a timer.
// assumes both ends share pclk; start is a one-cycle pulse.
`timescale 1ns/1ps
interface dbb_tmr_if #(parameter int CNT_W = 6);
    logic             start; // restart the interval
    logic [CNT_W-1:0] count; // programmed length
    logic             busy;  // interval running
    logic             done;  // last cycle of the interval
    modport ctl   (output start, output count, input busy, input done);
    modport timer (input start, input count, output busy, output done);
endinterface : dbb_tmr_if

// ---- core/dbb_dbtimer.sv ----
// dbb_dbtimer: dead-band interval, clock-counted or delay-chain timed.
// assumes start is synchronous to pclk; chain time rounds up to pclk.
`timescale 1ns/1ps
module dbb_dbtimer
    import dbb_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // mode: 1 selects the delay-chain time base
    input  wire logic chain_sel,
    // sequencer side
    dbb_tmr_if.timer  tmr
);
    typedef struct packed {
        logic             busy;  // interval active
        logic             chain; // mode latched at start
        logic [CNT_W-1:0] cnt;   // count latched at start
        logic [ACC_W-1:0] acc;   // elapsed ns since start
        logic [CNT_W-1:0] cyc;   // elapsed pclk periods
    } dbb_dbt_st_t;

    dbb_dbt_st_t      s_reg;  // registered state
    dbb_dbt_st_t      s_next; // next state
    logic [ACC_W-1:0] target; // interval length in ns

    // chain: elements * 5 ns; counter: periods * 25 ns
    assign target = s_reg.chain ? ACC_W'(s_reg.cnt * ELEM_NS)
                                : ACC_W'(s_reg.cnt * CLK_NS);
    assign tmr.busy = s_reg.busy;
    assign tmr.done = s_reg.busy && (s_reg.acc >= target);

    // next-state logic; a new start always restarts at one period elapsed
    always_comb begin
        s_next = s_reg;
        if (tmr.start) begin
            s_next.busy  = (tmr.count != '0); // zero count: no delay
            s_next.chain = chain_sel;
            s_next.cnt   = tmr.count;
            s_next.acc   = ACC_W'(CLK_NS);
            s_next.cyc   = CNT_W'(1);
        end else if (tmr.done) begin
            s_next.busy = 1'b0;
        end else if (s_reg.busy) begin
            s_next.acc = s_reg.acc + ACC_W'(CLK_NS); // one period more
            s_next.cyc = s_reg.cyc + CNT_W'(1);
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // counter mode lasts exactly the programmed periods
    property p_sync_len;
        @(posedge pclk) disable iff (!presetn)
        tmr.done && !s_reg.chain |-> s_reg.cyc == s_reg.cnt;
    endproperty
    a_sync_len: assert property (p_sync_len)
        else $error("counter dead-band length wrong");

    // chain mode covers elements*5ns within one period
    property p_chain_len;
        @(posedge pclk) disable iff (!presetn)
        tmr.done && s_reg.chain |->
            (s_reg.cyc * CLK_NS >= s_reg.cnt * ELEM_NS) &&
            ((s_reg.cyc - 1) * CLK_NS < s_reg.cnt * ELEM_NS);
    endproperty
    a_chain_len: assert property (p_chain_len)
        else $error("delay-chain dead-band length wrong");

    // zero count never runs
    property p_zero_off;
        @(posedge pclk) disable iff (!presetn)
        tmr.start && tmr.count == '0 |=> !tmr.busy;
    endproperty
    a_zero_off: assert property (p_zero_off)
        else $error("zero dead-band count still ran");
endmodule : dbb_dbtimer

// ---- core/dbb_blanker.sv ----
// dbb_blanker: blanking interval counted in pclk periods.
// assumes start is synchronous to pclk.
`timescale 1ns/1ps
module dbb_blanker
    import dbb_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // sequencer side
    dbb_tmr_if.timer  tmr
);
    typedef struct packed {
        logic             busy; // masking active
        logic [CNT_W-1:0] cnt;  // count latched at start
        logic [CNT_W-1:0] cyc;  // periods elapsed
    } dbb_blk_st_t;

    dbb_blk_st_t s_reg;  // registered state
    dbb_blk_st_t s_next; // next state

    assign tmr.busy = s_reg.busy;
    assign tmr.done = s_reg.busy && (s_reg.cyc == s_reg.cnt);

    // count from one up to the setting restart on start
    always_comb begin
        s_next = s_reg;
        if (tmr.start) begin
            s_next.busy = (tmr.count != '0); // zero: no mask
            s_next.cnt  = tmr.count;
            s_next.cyc  = CNT_W'(1);
        end else if (tmr.done) begin
            s_next.busy = 1'b0;
        end else if (s_reg.busy) begin
            s_next.cyc = s_reg.cyc + CNT_W'(1); // hold mask
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // once started the mask stays up until the count is reached
    property p_blank_hold;
        @(posedge pclk) disable iff (!presetn)
        s_reg.busy && s_reg.cyc < s_reg.cnt |=> s_reg.busy;
    endproperty
    a_blank_hold: assert property (p_blank_hold)
        else $error("blanking ended early");
endmodule : dbb_blanker

// ---- core/dbb_top.sv ----
// dbb_top: dead-band and input-blanking stage of a complementary output
// generator, with an APB register slave.
// assumes raw event sources arrive asynchronously on pins.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
module dbb_top
    import dbb_pkg::*;
(
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [dbb_pkg::ADDR_W-1:0] paddr,
    input  wire logic [dbb_pkg::DATA_W-1:0] pwdata,
    output logic      [dbb_pkg::DATA_W-1:0] prdata,
    output logic                           pready,
    output logic                           pslverr,
    // raw event sources, asynchronous
    input  wire logic                      rise_src,
    input  wire logic                      fall_src,
    // drives to the power stage
    output logic                           pri_drive,
    output logic                           cmp_drive,
    // accepted event strobes
    output logic                           rising_event,
    output logic                           falling_event
);
    typedef struct packed {
        logic [1:0]        rs;     // rise_src synchroniser
        logic [1:0]        fs;     // fall_src synchroniser
        logic              r_d;    // delayed synced rise level
        logic              f_d;    // delayed synced fall level
        logic [CTRL_W-1:0] ctrl;   // output_gen_control0
        logic [CNT_W-1:0]  rdb;    // rising_deadband_count
        logic [CNT_W-1:0]  fdb;    // falling_deadband_count
        logic [CNT_W-1:0]  rblk;   // rising blank count
        logic [CNT_W-1:0]  fblk;   // falling blank count
        dbb_state_t        st;     // output sequencer
        logic              pri;    // primary drive
        logic              cmp;    // complementary drive
        logic              r_evt;  // rising event strobe
        logic              f_evt;  // falling event strobe
        logic [DATA_W-1:0] rdata;  // read data held for access phase
    } dbb_top_st_t;

    dbb_top_st_t s_reg;   // registered state
    dbb_top_st_t s_next;  // next state

    // timer bundles
    dbb_tmr_if #(.CNT_W(CNT_W)) rdb_if ();  // rising dead-band
    dbb_tmr_if #(.CNT_W(CNT_W)) fdb_if ();  // falling dead-band
    dbb_tmr_if #(.CNT_W(CNT_W)) rblk_if (); // rising-started blanking
    dbb_tmr_if #(.CNT_W(CNT_W)) fblk_if (); // falling-started blanking

    logic en;          // generator enabled
    logic rise_edge;   // synced rising source edge
    logic fall_edge;   // synced falling source edge
    logic rise_acc;    // rising event past blanking
    logic fall_acc;    // falling event past blanking
    logic rise_go;     // rising event that changes the drives
    logic fall_go;     // falling event that changes the drives
    logic addr_ok;     // paddr hits a register
    logic wr_en;       // apb write completes this edge
    logic [DATA_W-1:0] status; // live status word

    // rising dead-band: chain or counter per select bit
    dbb_dbtimer u_rdb (
        .pclk      (pclk),
        .presetn   (presetn),
        .chain_sel (s_reg.ctrl[CTRL_RDS_BIT]),
        .tmr       (rdb_if.timer)
    );

    // falling dead-band: chain or counter per select bit
    dbb_dbtimer u_fdb (
        .pclk      (pclk),
        .presetn   (presetn),
        .chain_sel (s_reg.ctrl[CTRL_FDS_BIT]),
        .tmr       (fdb_if.timer)
    );

    // blanking started by a rising event, masks falling events
    dbb_blanker u_rblk (
        .pclk    (pclk),
        .presetn (presetn),
        .tmr     (rblk_if.timer)
    );

    // blanking started by a falling event, masks rising events
    dbb_blanker u_fblk (
        .pclk    (pclk),
        .presetn (presetn),
        .tmr     (fblk_if.timer)
    );

    // event detection; edges look only at the second sync stage, so the
    // pin-to-event latency is 2..3 periods, jitter at most one
    assign en        = s_reg.ctrl[CTRL_EN_BIT];
    assign rise_edge = s_reg.rs[1] & ~s_reg.r_d;
    assign fall_edge = s_reg.fs[1] & ~s_reg.f_d;
    // cross-coupled masks
    assign rise_acc  = en & rise_edge & ~fblk_if.busy;
    assign fall_acc  = en & fall_edge & ~rblk_if.busy;
    // a falling event wins when both arrive together: it is the safe way
    assign fall_go   = fall_acc & (s_reg.st != DBB_CMP_ON);
    assign rise_go   = rise_acc & ~fall_acc & (s_reg.st != DBB_PRI_ON);

    // timer requests; dead-band restarts on rise_go or fall_go, blanking on each strobed event
    assign rdb_if.start  = rise_go;
    assign rdb_if.count  = s_reg.rdb;
    assign fdb_if.start  = fall_go;
    assign fdb_if.count  = s_reg.fdb;
    assign rblk_if.start = rise_acc & ~fall_acc;
    assign rblk_if.count = s_reg.rblk;
    assign fblk_if.start = fall_acc;
    assign fblk_if.count = s_reg.fblk;

    // apb decode; zero wait states, errors only on unmapped offsets
    assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_RDB)  ||
                     (paddr == OFS_FDB)  || (paddr == OFS_RBLK) ||
                     (paddr == OFS_FBLK) || (paddr == OFS_STAT);
    assign wr_en   = psel & penable & pwrite & addr_ok;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = s_reg.rdata;

    // status word: drives and timer activity
    assign status = {26'h0000000, fblk_if.busy, rblk_if.busy,
                     fdb_if.busy, rdb_if.busy, s_reg.cmp, s_reg.pri};

    // outputs straight from flops
    assign pri_drive     = s_reg.pri;
    assign cmp_drive     = s_reg.cmp;
    assign rising_event  = s_reg.r_evt;
    assign falling_event = s_reg.f_evt;

    // next-state logic
    always_comb begin
        s_next       = s_reg;
        // synchronisers and edge history
        s_next.rs    = {s_reg.rs[0], rise_src};
        s_next.fs    = {s_reg.fs[0], fall_src};
        s_next.r_d   = s_reg.rs[1];
        s_next.f_d   = s_reg.fs[1];
        s_next.r_evt = rise_acc & ~fall_acc;
        s_next.f_evt = fall_acc;

        // register writes take effect on the access edge
        if (wr_en) begin
            unique case (paddr)
                OFS_CTRL: s_next.ctrl = pwdata[CTRL_W-1:0];
                OFS_RDB:  s_next.rdb  = pwdata[CNT_W-1:0];
                OFS_FDB:  s_next.fdb  = pwdata[CNT_W-1:0];
                OFS_RBLK: s_next.rblk = pwdata[CNT_W-1:0];
                OFS_FBLK: s_next.fblk = pwdata[CNT_W-1:0];
                default:  s_next.ctrl = s_reg.ctrl; // status is read-only
            endcase
        end

        // read data captured in the setup phase, shown in the access phase
        if (psel && !penable) begin
            unique case (paddr)
                OFS_CTRL: s_next.rdata = DATA_W'(s_reg.ctrl);
                OFS_RDB:  s_next.rdata = DATA_W'(s_reg.rdb);
                OFS_FDB:  s_next.rdata = DATA_W'(s_reg.fdb);
                OFS_RBLK: s_next.rdata = DATA_W'(s_reg.rblk);
                OFS_FBLK: s_next.rdata = DATA_W'(s_reg.fblk);
                OFS_STAT: s_next.rdata = status;
                default:  s_next.rdata = '0; // unmapped reads as zero
            endcase
        end

        // output sequencer
        if (!en) begin
            s_next.st = DBB_IDLE; // disabled: both drives off
        end else if (fall_go) begin
            // primary off at once; also cuts a running rising dead-band
            // so the falling interval extends it
            s_next.st = (s_reg.fdb == '0) ? DBB_CMP_ON
                                          : DBB_CMP_WAIT;
        end else if (rise_go) begin
            // complementary off at once, primary after dead-band
            s_next.st = (s_reg.rdb == '0) ? DBB_PRI_ON
                                          : DBB_PRI_WAIT;
        end else begin
            unique case (s_reg.st)
                DBB_PRI_WAIT: begin
                    if (rdb_if.done) begin
                        s_next.st = DBB_PRI_ON;
                    end
                end
                DBB_CMP_WAIT: begin
                    if (fdb_if.done) begin
                        s_next.st = DBB_CMP_ON;
                    end
                end
                DBB_IDLE, DBB_PRI_ON, DBB_CMP_ON: begin
                    s_next.st = s_reg.st;
                end
                default: begin
                    s_next.st = DBB_IDLE; // illegal code recovers off
                end
            endcase
        end

        // drives follow the next state, so they never overlap
        s_next.pri = (s_next.st == DBB_PRI_ON);
        s_next.cmp = (s_next.st == DBB_CMP_ON);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg      <= '0;
            s_reg.ctrl <= CTRL_RST;
            s_reg.rdb  <= CNT_RST;
            s_reg.fdb  <= CNT_RST;
            s_reg.rblk <= CNT_RST;
            s_reg.fblk <= CNT_RST;
            s_reg.st   <= DBB_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // the two drives are never on together
    property p_no_overlap;
        @(posedge pclk) disable iff (!presetn)
        !(pri_drive && cmp_drive);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("primary and complementary drive overlap");

    // end of rising dead-band turns the primary on next edge
    property p_pri_on;
        @(posedge pclk) disable iff (!presetn)
        s_reg.st == DBB_PRI_WAIT && rdb_if.done && !fall_acc && !rise_acc
            && en |=> pri_drive;
    endproperty
    a_pri_on: assert property (p_pri_on)
        else $error("primary late after rising dead-band");

    // falling event mid rising dead-band: wait, then complementary
    sequence s_rise_cut;
        s_reg.st == DBB_PRI_WAIT && fall_go && s_reg.fdb != '0;
    endsequence
    property p_rise_cut;
        @(posedge pclk) disable iff (!presetn)
        s_rise_cut |=> s_reg.st == DBB_CMP_WAIT && !pri_drive && !cmp_drive;
    endproperty
    a_rise_cut: assert property (p_rise_cut)
        else $error("rising-to-falling overlap mishandled");

    // rising event mid falling dead-band: wait, then primary
    sequence s_fall_cut;
        s_reg.st == DBB_CMP_WAIT && rise_go && s_reg.rdb != '0;
    endsequence
    property p_fall_cut;
        @(posedge pclk) disable iff (!presetn)
        s_fall_cut |=> s_reg.st == DBB_PRI_WAIT && !cmp_drive && !pri_drive;
    endproperty
    a_fall_cut: assert property (p_fall_cut)
        else $error("falling-to-rising overlap mishandled");

    // a masked rising edge changes nothing
    property p_rise_mask;
        @(posedge pclk) disable iff (!presetn)
        rise_edge && fblk_if.busy |=> !rising_event && !pri_drive;
    endproperty
    a_rise_mask: assert property (p_rise_mask)
        else $error("rising event passed during blanking");

    // zero falling dead-band switches the complementary on at once
    property p_fall_zero;
        @(posedge pclk) disable iff (!presetn)
        fall_go && s_reg.fdb == '0 |=> cmp_drive;
    endproperty
    a_fall_zero: assert property (p_fall_zero)
        else $error("zero falling dead-band still delayed");

    // a masked falling edge changes nothing
    property p_fall_mask;
        @(posedge pclk) disable iff (!presetn)
        fall_edge && rblk_if.busy |=> !falling_event && !cmp_drive;
    endproperty
    a_fall_mask: assert property (p_fall_mask)
        else $error("falling event passed during blanking");

    // zero rising dead-band switches the primary on at once
    property p_rise_zero;
        @(posedge pclk) disable iff (!presetn)
        rise_go && s_reg.rdb == '0 |=> pri_drive;
    endproperty
    a_rise_zero: assert property (p_rise_zero)
        else $error("zero rising dead-band still delayed");

    // end of falling dead-band turns the complementary on next edge
    property p_cmp_on;
        @(posedge pclk) disable iff (!presetn)
        s_reg.st == DBB_CMP_WAIT && fdb_if.done && !fall_acc && !rise_acc
            && en |=> cmp_drive;
    endproperty
    a_cmp_on: assert property (p_cmp_on)
        else $error("complementary late after falling dead-band");

    // primary held off while the rising dead-band still runs
    property p_pri_hold;
        @(posedge pclk) disable iff (!presetn)
        s_reg.st == DBB_PRI_WAIT && !rdb_if.done && !rise_go
            |=> !pri_drive;
    endproperty
    a_pri_hold: assert property (p_pri_hold)
        else $error("primary on before rising dead-band ended");

    // rising dead-band timing starts with the rising event strobe
    sequence s_rise_db;
        rise_go && s_reg.rdb != '0;
    endsequence
    property p_rise_start;
        @(posedge pclk) disable iff (!presetn)
        s_rise_db |=> rising_event && rdb_if.busy
            && s_reg.st == DBB_PRI_WAIT;
    endproperty
    a_rise_start: assert property (p_rise_start)
        else $error("rising dead-band did not start with its event");

    // falling dead-band timing starts with the falling event strobe
    sequence s_fall_db;
        fall_go && s_reg.fdb != '0;
    endsequence
    property p_fall_start;
        @(posedge pclk) disable iff (!presetn)
        s_fall_db |=> falling_event && fdb_if.busy
            && s_reg.st == DBB_CMP_WAIT;
    endproperty
    a_fall_start: assert property (p_fall_start)
        else $error("falling dead-band did not start with its event");
endmodule : dbb_top

// ---- sim/dbb_power_stage.sv ----
// dbb_power_stage: behavioural half-bridge fed by the two drives.
// assumes both drives are registered on pclk and active high.
`timescale 1ns/1ps
module dbb_power_stage (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // drives from the generator
    input  wire logic pri_drive,
    input  wire logic cmp_drive,
    // observations for the bench
    output logic      shoot_through,
    output int        pri_on_count
);
    logic pri_q; // last primary level, for edge counting
    // sticky flag: both switches closed would short the supply
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shoot_through <= 1'b0;
            pri_q         <= 1'b0;
            pri_on_count  <= 0;
        end else begin
            pri_q <= pri_drive;
            if (pri_drive && cmp_drive) begin
                shoot_through <= 1'b1;
            end
            if (pri_drive && !pri_q) begin // turn-on of primary switch
                pri_on_count <= pri_on_count + 1;
            end
        end
    end
endmodule : dbb_power_stage

// ---- sim/tb.sv ----
// tb: self-checking bench for dbb_top, apb master and event stimulus.
// assumes zero-wait apb slave; power stage model on the drives.
`timescale 1ns/1ps
module tb;
    import dbb_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = 8'h00; // apb address
    logic [DATA_W-1:0] pwdata = 32'h0, prdata, rd; // apb data
    logic pready, pslverr, err, shoot;
    logic rise_src = 0, fall_src = 0; // raw event pins
    logic pri_drive, cmp_drive, rising_event, falling_event;
    int   errors = 0, check_count = 0, n, ons;
    dbb_top dbb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rise_src(rise_src), .fall_src(fall_src), .pri_drive(pri_drive),
        .cmp_drive(cmp_drive), .rising_event(rising_event),
        .falling_event(falling_event));
    dbb_power_stage dbb_power_stage_i (.pclk(pclk), .presetn(presetn),
        .pri_drive(pri_drive), .cmp_drive(cmp_drive),
        .shoot_through(shoot), .pri_on_count(ons));
    // 40 MHz clock
    always #12.5 pclk = ~pclk;
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; request held until pready sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // wait for the accepted-event strobe, bounded
    task wait_ev(input bit r);
        int k;
        k = 0;
        do begin @(posedge pclk); #1; k++; end
        while ((r ? rising_event : falling_event) !== 1'b1 && k < 12);
        chk(k < 12, 1);
    endtask : wait_ev
    // off cycles from the event strobe until the drive turns on
    task count_on(input bit r);
        n = 0;
        while ((r ? pri_drive : cmp_drive) !== 1'b1 && n < 80) begin
            n++; @(posedge pclk); #1;
        end
    endtask : count_on
    // one event through the pin, then measure the dead-band
    task fire(input bit r, input int exp);
        @(posedge pclk);
        if (r) rise_src <= 1; else fall_src <= 1;
        wait_ev(r);
        chk(r ? cmp_drive : pri_drive, 0);
        count_on(r);
        chk(n, exp);
        @(posedge pclk);
        rise_src <= 0; fall_src <= 0;
        repeat (2) @(posedge pclk);
    endtask : fire
    // control reset value, 6-bit count truncation, error-free status write, unmapped address
    task t_regs;
        apb(0, OFS_CTRL, 0); chk(rd, 0);
        apb(1, OFS_RDB, 32'hFF); apb(0, OFS_RDB, 0); chk(rd, 32'h3F);
        apb(1, OFS_STAT, 32'hFF); chk(err, 0);
        apb(0, 8'h20, 0); chk(err, 1); chk(rd, 0);
    endtask : t_regs
    // clock-counted dead-band, zero count and both directions
    task t_sync;
        apb(1, OFS_CTRL, 1); apb(1, OFS_FDB, 0);
        fire(0, 0);
        apb(1, OFS_RDB, 3); fire(1, 3);
        apb(0, OFS_STAT, 0); chk(rd, 32'h1);
        apb(1, OFS_FDB, 2); fire(0, 2);
        apb(1, OFS_RDB, 0); fire(1, 0);
    endtask : t_sync
    // delay chain: elements of 5 ns rounded up to whole periods
    task t_chain;
        apb(1, OFS_CTRL, 7);
        apb(1, OFS_FDB, 11); fire(0, (11 * ELEM_NS + CLK_NS - 1) / CLK_NS);
        apb(1, OFS_RDB, 7); fire(1, (7 * ELEM_NS + CLK_NS - 1) / CLK_NS);
    endtask : t_chain
    // an opposite event lands inside a running dead-band
    task t_overlap(input bit r);
        int o;
        apb(1, OFS_CTRL, 1);
        apb(1, OFS_RDB, r ? 20 : 2); apb(1, OFS_FDB, r ? 2 : 20);
        fire(!r, 2);
        o = ons;
        @(posedge pclk);
        if (r) rise_src <= 1; else fall_src <= 1;
        wait_ev(r);
        @(posedge pclk);
        if (r) fall_src <= 1; else rise_src <= 1;
        wait_ev(!r);
        count_on(!r);
        chk(n, 2);
        @(posedge pclk); rise_src <= 0; fall_src <= 0;
        repeat (2) @(posedge pclk);
        chk(ons, o + !r);
    endtask : t_overlap
    // count accepted events of one kind over seven cycles
    task quiet(input bit r);
        n = 0;
        repeat (7) begin
            @(posedge pclk); #1;
            n += r ? rising_event : falling_event;
        end
    endtask : quiet
    // each blanking counter masks the opposite event, then releases
    task t_blank;
        apb(1, OFS_RDB, 0); apb(1, OFS_FDB, 0);
        apb(1, OFS_RBLK, 8); apb(1, OFS_FBLK, 8);
        fire(1, 0);
        @(posedge pclk); fall_src <= 1;
        quiet(0);
        chk(n, 0);
        chk(cmp_drive, 0);
        @(posedge pclk); fall_src <= 0;
        repeat (2) @(posedge pclk);
        fire(0, 0);
        @(posedge pclk); rise_src <= 1;
        quiet(1);
        chk(n, 0);
        chk(pri_drive, 0);
        @(posedge pclk); rise_src <= 0;
        repeat (2) @(posedge pclk);
        fire(1, 0);
    endtask : t_blank
    // verdict
    task end_of_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    // watchdog, well above the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        end_of_test;
    end
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        t_regs; t_sync; t_chain; t_overlap(1); t_overlap(0); t_blank;
        chk(shoot, 0);
        end_of_test;
    end
endmodule : tb
